// file: spr_map.svh
// Register map, field positions and frame constants of the serial register port
// Functional notes
// - Frame is two bytes: command then data in, status then register data out.
// - Select falling starts a frame and drives the serial output.
// - Output changes on clock rise; input sampled on clock fall.
// - Frame valid only with exactly sixteen sampling edges while selected.
// - Write data enters the register on the select rising edge.
// - Read data is captured while the parity bit is shifted.
// - Serial output released whenever select is high.
// - Read command: second master byte ignored, register data returned.
// - Write command: old register value returned during the write.
// - Parity checked on writes only; the spare command bit is ignored.
// - First returned byte is always the system status register.
// - Addresses one through twelve each select an 8-bit register.
// - Run mode: enabled hall input change sets the hall flag.
// - Stop mode: cyclic check plus enabled hall current sets the hall flag.
// - Flags other than the overcurrent summary clear on writing one, ignore zero; all clear on reset.
// - Every falling edge on the bus line sets the bus wake flag.
// - Temperature and voltage flags stay set while their condition persists.
// - Overcurrent summary is read-only, cleared through the source flags.
// - Interrupt requested when a flag and its enable are both set.
// - All interrupt enables are off after reset.
`ifndef SPR_MAP_SVH
`define SPR_MAP_SVH
`define SPR_A_BRIDGE_OUTPUT_STATES 5'h01
`define SPR_A_BRIDGE_CONTROL 5'h02
`define SPR_A_SYSTEM_CONTROL 5'h03
`define SPR_A_IMR 5'h04
`define SPR_A_IFR 5'h05
`define SPR_A_RMR 5'h06
`define SPR_A_MUX 5'h07
`define SPR_A_HEN 5'h08
`define SPR_A_HST 5'h09
`define SPR_A_WDG 5'h0A
`define SPR_A_POWER_OUTPUT_CONTROL 5'h0B
`define SPR_A_STAT 5'h0C
`define SPR_M_BRIDGE_OUTPUT_STATES 8'hFF
`define SPR_M_BRIDGE_CONTROL 8'hC7
`define SPR_M_SYSTEM_CONTROL 8'hE0
`define SPR_M_IMR 8'h7E
`define SPR_M_RMR 8'h83
`define SPR_M_MUX 8'h0F
`define SPR_M_HEN 8'h07
`define SPR_M_WDG 8'h3F
`define SPR_M_POWER_OUTPUT_CONTROL 8'h3F
`define SPR_F_HALL 6
`define SPR_F_LIN 5
`define SPR_F_HT 4
`define SPR_F_LV 3
`define SPR_F_HV 2
`define SPR_F_OC 1
`define SPR_S_LINCL 6
`define SPR_S_OCHV 5
`define SPR_S_OCHS 4
`define SPR_S_LV 3
`define SPR_S_HV 2
`define SPR_S_OCHB 1
`define SPR_S_HT 0
`define SPR_W_CC 2
`define SPR_C_RW 15
`define SPR_C_AHI 14
`define SPR_C_ALO 10
`define SPR_C_PAR 9
`define SPR_E_AHI 5
`define SPR_E_ALO 1
`define SPR_EDGES 5'd16
`define SPR_EDGE_MAX 5'd17
`define SPR_PAR_EDGE 5'd6
`define SPR_BYTE 5'd8
`define SPR_I_SS 0
`define SPR_I_SCK 1
`define SPR_I_MOSI 2
`define SPR_I_LIN 3
`define SPR_I_LINCL 4
`define SPR_I_STOP 5
`define SPR_I_OT 6
`define SPR_I_UV 7
`define SPR_I_OV 8
`define SPR_I_OCLO 9
`define SPR_I_OCHI 11
`define SPR_I_HLO 12
`define SPR_I_HHI 14
`define SPR_I_CLO 15
`define SPR_I_CHI 17
`define SPR_IN_W 18
`endif

// file: spr_pkg.sv
// Types of the serial register port
package spr_pkg;
  typedef enum logic [0:0] {SPR_IDLE = 1'b0, SPR_ACT = 1'b1} spr_state_e;
  typedef struct packed {
    spr_state_e st;
    logic [17:0] s1;
    logic [17:0] s2;
    logic [17:0] prev;
    logic [4:0] fcnt;
    logic [4:0] rcnt;
    logic [15:0] rx;
    logic [7:0] stat;
    logic [7:0] dsnap;
    logic miso;
    logic irq;
    logic [7:0] bridge_output_states;
    logic [7:0] bridge_control;
    logic [7:0] system_control;
    logic [7:0] interrupt_enable_mask;
    logic [7:0] reset_source_mask;
    logic [7:0] mux;
    logic [7:0] hen;
    logic [7:0] wdg;
    logic [7:0] power_output_control;
    logic hall_f;
    logic lin_f;
    logic ht_f;
    logic lv_f;
    logic hv_f;
    logic [2:0] oc;
  } spr_regs_s;
endpackage

// file: spr_port.sv
// Serial register port with interrupt flags of the companion die
`include "spr_map.svh"
module spr_port import spr_pkg::*; (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic SS_N,
  input wire logic SCK,
  input wire logic MOSI,
  output logic MISO,
  output logic MISO_OE,
  input wire logic LIN_RX,
  input wire logic LIN_CL,
  input wire logic STOP_MODE,
  input wire logic OVER_TEMP,
  input wire logic UNDER_VOLT,
  input wire logic OVER_VOLT,
  input wire logic [2:0] OC_SRC,
  input wire logic [2:0] HALL_IN,
  input wire logic [2:0] HALL_CUR,
  output logic IRQ_N_OUT,
  output logic IRQ_N_OE,
  output logic [7:0] BRIDGE_OUT,
  output logic [7:0] BRIDGE_CTL,
  output logic [7:0] SYS_CTL,
  output logic [7:0] RESET_MASK,
  output logic [7:0] MUX_SEL,
  output logic [7:0] HALL_EN,
  output logic [7:0] WDOG_CTL,
  output logic [7:0] POWER_CTL
);

  spr_regs_s q;
  spr_regs_s next_q;
  logic [17:0] in_raw;
  logic sck_rise;
  logic sck_fall;
  logic wr;
  logic [4:0] wa;
  logic [7:0] wd;
  logic [7:0] clr_ifr;
  logic [7:0] clr_st;
  logic [7:0] status;
  logic [7:0] flags;
  logic hall_set;

  assign in_raw = {HALL_CUR, HALL_IN, OC_SRC, OVER_VOLT, UNDER_VOLT, OVER_TEMP,
                   STOP_MODE, LIN_CL, LIN_RX, MOSI, SCK, SS_N};

  function automatic logic [7:0] rd(input spr_regs_s r, input logic [4:0] a,
                                    input logic [7:0] st, input logic [7:0] fl);
    case (a)
      `SPR_A_BRIDGE_OUTPUT_STATES: rd = r.bridge_output_states;
      `SPR_A_BRIDGE_CONTROL: rd = r.bridge_control;
      `SPR_A_SYSTEM_CONTROL: rd = r.system_control;
      `SPR_A_IMR: rd = r.interrupt_enable_mask;
      `SPR_A_IFR: rd = fl;
      `SPR_A_RMR: rd = r.reset_source_mask;
      `SPR_A_MUX: rd = r.mux;
      `SPR_A_HEN: rd = r.hen;
      `SPR_A_HST: rd = {5'h00, r.s2[`SPR_I_HHI:`SPR_I_HLO]};
      `SPR_A_WDG: rd = r.wdg;
      `SPR_A_POWER_OUTPUT_CONTROL: rd = r.power_output_control;
      `SPR_A_STAT: rd = st;
      default: rd = 8'h00;
    endcase
  endfunction

  always_comb begin
    next_q = q;
    // Only the second stage of each synchroniser and its delayed copy feed logic
    next_q.s1 = in_raw;
    next_q.s2 = q.s1;
    next_q.prev = q.s2;
    sck_rise = q.s2[`SPR_I_SCK] & ~q.prev[`SPR_I_SCK];
    sck_fall = ~q.s2[`SPR_I_SCK] & q.prev[`SPR_I_SCK];
    status = 8'h00;
    status[`SPR_S_LINCL] = q.s2[`SPR_I_LINCL];
    status[`SPR_S_OCHV] = q.oc[2];
    status[`SPR_S_OCHS] = q.oc[1];
    status[`SPR_S_LV] = q.lv_f;
    status[`SPR_S_HV] = q.hv_f;
    status[`SPR_S_OCHB] = q.oc[0];
    status[`SPR_S_HT] = q.ht_f;
    flags = 8'h00;
    flags[`SPR_F_HALL] = q.hall_f;
    flags[`SPR_F_LIN] = q.lin_f;
    flags[`SPR_F_HT] = q.ht_f;
    flags[`SPR_F_LV] = q.lv_f;
    flags[`SPR_F_HV] = q.hv_f;
    flags[`SPR_F_OC] = |q.oc;
    wa = q.rx[`SPR_C_AHI:`SPR_C_ALO];
    wd = q.rx[7:0];
    wr = 1'b0;
    case (q.st)
      SPR_IDLE: begin
        if (!q.s2[`SPR_I_SS]) begin
          next_q.st = SPR_ACT;
          next_q.fcnt = 5'd0;
          next_q.rcnt = 5'd0;
          next_q.miso = 1'b0;
          next_q.stat = status;
        end
      end
      SPR_ACT: begin
        if (q.s2[`SPR_I_SS]) begin
          next_q.st = SPR_IDLE;
          // Spare bit and read parity ignored; bad frames write nothing
          wr = (q.fcnt == `SPR_EDGES) && !q.rx[`SPR_C_RW] &&
               !(^q.rx[`SPR_C_RW:`SPR_C_PAR]);
        end else begin
          if (sck_rise) begin
            // Status byte first, then captured register byte
            if (q.rcnt < `SPR_BYTE) begin
              next_q.miso = q.stat[~q.rcnt[2:0]];
            end else begin
              next_q.miso = q.dsnap[~q.rcnt[2:0]];
            end
            if (q.rcnt != `SPR_EDGE_MAX) begin
              next_q.rcnt = q.rcnt + 5'd1;
            end
          end
          if (sck_fall) begin
            next_q.rx = {q.rx[14:0], q.s2[`SPR_I_MOSI]};
            if (q.fcnt != `SPR_EDGE_MAX) begin
              next_q.fcnt = q.fcnt + 5'd1;
            end
            if (q.fcnt == `SPR_PAR_EDGE) begin
              // Address is complete once the parity bit is in
              next_q.dsnap = rd(q, next_q.rx[`SPR_E_AHI:`SPR_E_ALO],
                                status, flags);
            end
          end
        end
      end
      default: next_q.st = SPR_IDLE;
    endcase
    clr_ifr = (wr && wa == `SPR_A_IFR) ? wd : 8'h00;
    clr_st = (wr && wa == `SPR_A_STAT) ? wd : 8'h00;
    if (q.s2[`SPR_I_STOP]) begin
      hall_set = q.wdg[`SPR_W_CC] &
                 (|(q.s2[`SPR_I_CHI:`SPR_I_CLO] & q.hen[2:0]));
    end else begin
      hall_set = |((q.s2[`SPR_I_HHI:`SPR_I_HLO] ^ q.prev[`SPR_I_HHI:`SPR_I_HLO]) &
                   q.hen[2:0]);
    end
    // Set beats a clear arriving in the same cycle
    next_q.hall_f = hall_set | (q.hall_f & ~clr_ifr[`SPR_F_HALL]);
    next_q.lin_f = (q.prev[`SPR_I_LIN] & ~q.s2[`SPR_I_LIN]) |
                   (q.lin_f & ~clr_ifr[`SPR_F_LIN]);
    next_q.ht_f = q.s2[`SPR_I_OT] |
                  (q.ht_f & ~clr_ifr[`SPR_F_HT] & ~clr_st[`SPR_S_HT]);
    next_q.lv_f = q.s2[`SPR_I_UV] |
                  (q.lv_f & ~clr_ifr[`SPR_F_LV] & ~clr_st[`SPR_S_LV]);
    next_q.hv_f = q.s2[`SPR_I_OV] |
                  (q.hv_f & ~clr_ifr[`SPR_F_HV] & ~clr_st[`SPR_S_HV]);
    next_q.oc = q.s2[`SPR_I_OCHI:`SPR_I_OCLO] |
                (q.oc & ~{clr_st[`SPR_S_OCHV], clr_st[`SPR_S_OCHS],
                          clr_st[`SPR_S_OCHB]});
    if (wr) begin
      case (wa)
        `SPR_A_BRIDGE_OUTPUT_STATES: next_q.bridge_output_states = wd & `SPR_M_BRIDGE_OUTPUT_STATES;
        `SPR_A_BRIDGE_CONTROL: next_q.bridge_control = wd & `SPR_M_BRIDGE_CONTROL;
        `SPR_A_SYSTEM_CONTROL: next_q.system_control = wd & `SPR_M_SYSTEM_CONTROL;
        `SPR_A_IMR: next_q.interrupt_enable_mask = wd & `SPR_M_IMR;
        `SPR_A_RMR: next_q.reset_source_mask = wd & `SPR_M_RMR;
        `SPR_A_MUX: next_q.mux = wd & `SPR_M_MUX;
        `SPR_A_HEN: next_q.hen = wd & `SPR_M_HEN;
        `SPR_A_WDG: next_q.wdg = wd & `SPR_M_WDG;
        `SPR_A_POWER_OUTPUT_CONTROL: next_q.power_output_control = wd & `SPR_M_POWER_OUTPUT_CONTROL;
        default: next_q.bridge_output_states = q.bridge_output_states;
      endcase
    end
    next_q.irq = |(flags & q.interrupt_enable_mask);
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      q <= '0;
      // Select stages rest deselected, so no false frame follows reset
      q.s1[`SPR_I_SS] <= 1'b1;
      q.s2[`SPR_I_SS] <= 1'b1;
      q.prev[`SPR_I_SS] <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign MISO = q.miso;
  assign MISO_OE = (q.st == SPR_ACT);
  assign IRQ_N_OUT = 1'b0;
  assign IRQ_N_OE = q.irq;
  assign BRIDGE_OUT = q.bridge_output_states;
  assign BRIDGE_CTL = q.bridge_control;
  assign SYS_CTL = q.system_control;
  assign RESET_MASK = q.reset_source_mask;
  assign MUX_SEL = q.mux;
  assign HALL_EN = q.hen;
  assign WDOG_CTL = q.wdg;
  assign POWER_CTL = q.power_output_control;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  chk_select_release: assert property (
    q.st == SPR_ACT && q.s2[`SPR_I_SS] |=> !MISO_OE)
    else $error("output not released after select rose");
  chk_select_drive: assert property (
    q.st == SPR_IDLE && !q.s2[`SPR_I_SS] |=> MISO_OE ##0 MISO == 1'b0)
    else $error("output not driven at frame start");
  chk_status_first: assert property (
    MISO_OE && sck_rise && q.rcnt == 5'd0 && !q.s2[`SPR_I_SS] |=> MISO == q.stat[7])
    else $error("first bit is not status msb");
  chk_bad_count: assert property (
    q.st == SPR_ACT && q.s2[`SPR_I_SS] && q.fcnt != `SPR_EDGES |=>
    $stable(q.bridge_output_states) && $stable(q.interrupt_enable_mask) && $stable(q.power_output_control))
    else $error("register written by short or long frame");
  chk_read_no_write: assert property (
    q.st == SPR_ACT && q.s2[`SPR_I_SS] && q.rx[`SPR_C_RW] |=>
    $stable(q.bridge_output_states) && $stable(q.hen) && $stable(q.mux))
    else $error("read frame changed a register");
  chk_write_at_end: assert property (
    $changed(q.bridge_output_states) |-> $past(q.st) == SPR_ACT && $past(q.s2[`SPR_I_SS]))
    else $error("register changed away from select rise");
  chk_flag_hold: assert property (
    q.s2[`SPR_I_UV] |=> q.lv_f [*2])
    else $error("low voltage flag lost while condition present");
  chk_oc_summary: assert property (
    |q.oc && q.interrupt_enable_mask[`SPR_F_OC] |=> IRQ_N_OE)
    else $error("overcurrent not reaching interrupt");
  chk_irq_gate: assert property (
    !IRQ_N_OE && ((q.lin_f && q.interrupt_enable_mask[`SPR_F_LIN]) || (q.hall_f && q.interrupt_enable_mask[`SPR_F_HALL]))
    |=> IRQ_N_OE)
    else $error("enabled flag gave no interrupt");
  chk_wake_edge: assert property (
    q.prev[`SPR_I_LIN] && !q.s2[`SPR_I_LIN] |=> q.lin_f)
    else $error("bus falling edge did not set wake flag");

  cov_write_frame: cover property (
    q.st == SPR_ACT && q.s2[`SPR_I_SS] && wr);
  cov_read_frame: cover property (
    q.st == SPR_ACT && q.s2[`SPR_I_SS] && q.fcnt == `SPR_EDGES && q.rx[`SPR_C_RW]);
  cov_irq: cover property ($rose(IRQ_N_OE));
  cov_bad_parity: cover property (
    q.st == SPR_ACT && q.s2[`SPR_I_SS] && q.fcnt == `SPR_EDGES && !q.rx[`SPR_C_RW] &&
    (^q.rx[`SPR_C_RW:`SPR_C_PAR]));

endmodule // spr_port

// file: spr_master_model.sv
// Serial master model that frames transfers into the register port
module spr_master_model (
  input wire logic CLOCK,
  output logic SS_N,
  output logic SCK,
  output logic MOSI,
  input wire logic MISO
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    SS_N = 1'b1;
    SCK = 1'b0;
    MOSI = 1'b0;
  end
  // Shift clock stands low outside frames; 8 cycles a phase gives 40 ns
  task automatic frame(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    SS_N <= 1'b0;
    repeat (8) @(posedge CLOCK);
    for (int i = 0; i < nbits; i++) begin
      MOSI <= tx[(i < 16) ? 15 - i : 0];
      SCK <= 1'b1;
      repeat (8) @(posedge CLOCK);
      rx = {rx[14:0], MISO};
      SCK <= 1'b0;
      repeat (8) @(posedge CLOCK);
    end
    SS_N <= 1'b1;
    // Released line must not keep its last level
    MOSI <= ~MOSI;
    repeat (8) @(posedge CLOCK);
  endtask
endmodule // spr_master_model

// file: testbench.sv
// Self-checking bench for the serial register port
`include "spr_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK, SRST, SS_N, SCK, MOSI, MISO, MISO_OE, LIN_RX, LIN_CL, STOP_MODE;
  logic OVER_TEMP, UNDER_VOLT, OVER_VOLT, IRQ_N_OUT, IRQ_N_OE;
  logic [2:0] OC_SRC, HALL_IN, HALL_CUR;
  logic [7:0] BRIDGE_OUT, BRIDGE_CTL, SYS_CTL, RESET_MASK, MUX_SEL, HALL_EN, WDOG_CTL, POWER_CTL;
  logic [7:0] st, rd;
  wire miso_line;
  int fail_count = 0;
  int checked = 0;
  localparam logic [4:0] wa [9] = '{`SPR_A_BRIDGE_OUTPUT_STATES, `SPR_A_BRIDGE_CONTROL, `SPR_A_SYSTEM_CONTROL, `SPR_A_IMR,
    `SPR_A_RMR, `SPR_A_MUX, `SPR_A_HEN, `SPR_A_WDG, `SPR_A_POWER_OUTPUT_CONTROL};
  localparam logic [7:0] wm [9] = '{8'hFF, 8'hC7, 8'hE0, 8'h7E, 8'h83, 8'h0F, 8'h07, 8'h3F, 8'h3F};
  localparam logic [7:0] ocs [3] = '{8'h02, 8'h10, 8'h20};
  localparam logic [7:0] cst [3] = '{8'h01, 8'h08, 8'h04};
  assign miso_line = MISO_OE ? MISO : 1'bz;
  spr_master_model u_master (.CLOCK(CLOCK), .SS_N(SS_N), .SCK(SCK), .MOSI(MOSI), .MISO(miso_line));
  spr_port u_dut (.CLOCK(CLOCK), .SRST(SRST), .SS_N(SS_N), .SCK(SCK), .MOSI(MOSI), .MISO(MISO),
    .MISO_OE(MISO_OE), .LIN_RX(LIN_RX), .LIN_CL(LIN_CL), .STOP_MODE(STOP_MODE),
    .OVER_TEMP(OVER_TEMP), .UNDER_VOLT(UNDER_VOLT), .OVER_VOLT(OVER_VOLT), .OC_SRC(OC_SRC),
    .HALL_IN(HALL_IN), .HALL_CUR(HALL_CUR), .IRQ_N_OUT(IRQ_N_OUT), .IRQ_N_OE(IRQ_N_OE),
    .BRIDGE_OUT(BRIDGE_OUT), .BRIDGE_CTL(BRIDGE_CTL), .SYS_CTL(SYS_CTL),
    .RESET_MASK(RESET_MASK), .MUX_SEL(MUX_SEL), .HALL_EN(HALL_EN), .WDOG_CTL(WDOG_CTL),
    .POWER_CTL(POWER_CTL));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (fail_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Spare command bit is always set: it must carry no meaning
  task automatic xfer(input logic rw, input logic [4:0] a, input logic [7:0] d,
    input logic bad = 1'b0, input int n = 16);
    logic [15:0] rx;
    u_master.frame({rw, a, ^{rw, a, bad}, 1'b1, d}, n, rx);
    st = rx[15:8];
    rd = rx[7:0];
    check({7'h00, MISO_OE}, 8'h00);
  endtask
  task automatic reset_values;
    for (int a = 0; a < 32; a++) begin
      xfer(1'b1, 5'(a), 8'hA5, a[0]);
      check(st, 8'h00);
      check(rd, 8'h00);
    end
  endtask
  task automatic write_readback;
    for (int i = 0; i < 9; i++) begin
      xfer(1'b0, wa[i], 8'hFF);
      check(rd, 8'h00);
      xfer(1'b1, wa[i], 8'h00);
      check(rd, wm[i]);
      xfer(1'b0, wa[i], 8'h00, 1'b1);
      xfer(1'b0, wa[i], 8'h00, 1'b0, 15);
      xfer(1'b0, wa[i], 8'h00, 1'b0, 17);
      xfer(1'b0, wa[i], 8'h00);
      check(rd, wm[i]);
    end
    xfer(1'b0, `SPR_A_BRIDGE_OUTPUT_STATES, 8'h3C);
    check(BRIDGE_OUT, 8'h3C);
    for (int i = 0; i < 9; i++) begin
      xfer(1'b0, wa[i], 8'hFF);
    end
    check(BRIDGE_CTL, 8'hC7);
    check(SYS_CTL, 8'hE0);
    check(RESET_MASK, 8'h83);
    check(MUX_SEL, 8'h0F);
    check(HALL_EN, 8'h07);
    check(WDOG_CTL, 8'h3F);
    check(POWER_CTL, 8'h3F);
    check({7'h00, IRQ_N_OUT}, 8'h00);
    xfer(1'b0, `SPR_A_WDG, 8'h00);
    xfer(1'b0, `SPR_A_HEN, 8'h00);
    xfer(1'b0, `SPR_A_IMR, 8'h00);
    xfer(1'b0, `SPR_A_HST, 8'hFF);
    xfer(1'b1, `SPR_A_HST, 8'h00);
    check(rd, 8'h00);
  endtask
  task automatic lin_wake_flag;
    xfer(1'b0, `SPR_A_IMR, 8'h20);
    LIN_RX <= 1'b0;
    repeat (8) @(posedge CLOCK);
    LIN_RX <= 1'b1;
    repeat (8) @(posedge CLOCK);
    check({7'h00, IRQ_N_OE}, 8'h01);
    xfer(1'b0, `SPR_A_IFR, 8'hDF);
    check(rd, 8'h20);
    xfer(1'b0, `SPR_A_IFR, 8'h20);
    check(rd, 8'h20);
    xfer(1'b1, `SPR_A_IFR, 8'h00);
    check(rd, 8'h00);
    check({7'h00, IRQ_N_OE}, 8'h00);
  endtask
  // Enable mask still only covers the bus wake flag here
  task automatic held_conditions;
    for (int i = 0; i < 3; i++) begin
      {OVER_VOLT, UNDER_VOLT, OVER_TEMP} <= 3'(1 << i);
      repeat (8) @(posedge CLOCK);
      check({7'h00, IRQ_N_OE}, 8'h00);
      xfer(1'b0, `SPR_A_IFR, 8'h10 >> i);
      check(st, cst[i]);
      xfer(1'b1, `SPR_A_IFR, 8'h00);
      check(rd, 8'h10 >> i);
      {OVER_VOLT, UNDER_VOLT, OVER_TEMP} <= 3'b000;
      xfer(1'b0, `SPR_A_IFR, 8'h10 >> i);
      xfer(1'b1, `SPR_A_IFR, 8'h00);
      check(rd, 8'h00);
    end
  endtask
  task automatic overcurrent;
    for (int i = 0; i < 3; i++) begin
      OC_SRC <= 3'(1 << i);
      repeat (8) @(posedge CLOCK);
      OC_SRC <= 3'b000;
      xfer(1'b0, `SPR_A_IFR, 8'h02);
      check(st, ocs[i]);
      xfer(1'b0, `SPR_A_STAT, ocs[i]);
      check(rd, ocs[i]);
      xfer(1'b1, `SPR_A_IFR, 8'h00);
      check(rd, 8'h00);
      check(st, 8'h00);
    end
  endtask
  task automatic hall_flag;
    xfer(1'b0, `SPR_A_HEN, 8'h01);
    HALL_IN <= 3'b010;
    xfer(1'b1, `SPR_A_IFR, 8'h00);
    check(rd, 8'h00);
    HALL_IN <= 3'b011;
    xfer(1'b0, `SPR_A_IFR, 8'h40);
    check(rd, 8'h40);
    STOP_MODE <= 1'b1;
    HALL_CUR <= 3'b001;
    xfer(1'b1, `SPR_A_IFR, 8'h00);
    check(rd, 8'h00);
    xfer(1'b0, `SPR_A_WDG, 8'h04);
    xfer(1'b1, `SPR_A_IFR, 8'h00);
    check(rd, 8'h40);
  endtask
  initial begin
    CLOCK = 1'b0;
    forever #2.5 CLOCK = ~CLOCK;
  end
  // Frames have bounded length, so one overall limit catches a hang
  initial begin
    #400us;
    fail_count++;
    complete_run;
  end
  initial begin
    SRST = 1'b1;
    {LIN_RX, LIN_CL, STOP_MODE, OVER_TEMP, UNDER_VOLT, OVER_VOLT} = 6'h20;
    {OC_SRC, HALL_IN, HALL_CUR} = 9'h000;
    repeat (2) @(posedge CLOCK);
    SRST <= 1'b0;
    repeat (4) @(posedge CLOCK);
    reset_values;
    write_readback;
    lin_wake_flag;
    held_conditions;
    overcurrent;
    hall_flag;
    complete_run;
  end
endmodule // testbench
